// [include/i2cst_map.vh]
`ifndef I2CST_MAP_VH
`define I2CST_MAP_VH
// register byte offsets
`define I2CST_OFF_CLOCK_CONFIG 8'h1c
`define I2CST_OFF_RISE_TIME 8'h20
`define I2CST_OFF_FAST_PLUS 8'h90
`define I2CST_OFF_CONTROL 8'h94
`define I2CST_OFF_STATUS 8'h98
// field positions
`define I2CST_FAST_BIT 15
`define I2CST_DUTY_BIT 14
`define I2CST_PERIOD_MSB 11
`define I2CST_RISE_MSB 6
`define I2CST_FMP_BIT 0
`define I2CST_RUN_BIT 0
// reset values
`define I2CST_CLOCK_CONFIG_RST 32'h0000_0000
`define I2CST_RISE_TIME_RST 7'h02
`define I2CST_FAST_PLUS_RST 1'b0
// timing multipliers of the period count
`define I2CST_MUL_STD_HIGH 5'h01
`define I2CST_MUL_STD_LOW 5'h01
`define I2CST_MUL_FAST_HIGH 5'h01
`define I2CST_MUL_FAST_LOW 5'h02
`define I2CST_MUL_DUTY_HIGH 5'h09
`define I2CST_MUL_DUTY_LOW 5'h10
// axi responses
`define I2CST_RESP_OKAY 2'h0
`define I2CST_RESP_SLVERR 2'h2
`endif

// [hw/i2cst_half_timer.v]
`timescale 1ns/1ps
`include "i2cst_map.vh"
module i2cst_half_timer #(
  parameter CW = 17
) (
  input wire clk,
  input wire arst_n,
  input wire run,
  input wire [CW-1:0] half_high,
  input wire [CW-1:0] half_low,
  output reg scl_level,
  output reg toggle
);
  reg [CW-1:0] count;
  reg [CW-1:0] next_count;
  reg next_level;
  reg next_toggle;

  // counts peripheral clocks per half period, reloads at each edge of scl
  always @* begin
    next_count = count;
    next_level = scl_level;
    next_toggle = 1'b0;
    if (!run) begin
      next_count = half_high;
      next_level = 1'b1;
    end else if (count <= {{(CW-1){1'b0}}, 1'b1}) begin
      next_level = ~scl_level;
      next_toggle = 1'b1;
      next_count = scl_level ? half_low : half_high;
    end else begin
      next_count = count - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= {CW{1'b0}};
      scl_level <= 1'b1;
      toggle <= 1'b0;
    end else begin
      count <= next_count;
      scl_level <= next_level;
      toggle <= next_toggle;
    end
  end
endmodule

// [hw/i2cst_scl_timing.v]
`timescale 1ns/1ps
`include "i2cst_map.vh"
module i2cst_scl_timing #(
  parameter PW = 12,
  parameter CW = 17
) (
  input wire clk,
  input wire arst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire scl_out,
  output wire scl_oe_n,
  output wire fast_plus_enable,
  output wire [6:0] rise_time_limit
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg fast_speed;
  reg duty_select;
  reg [PW-1:0] scl_period_count;
  reg [6:0] rise_time;
  reg fast_plus;
  reg run;
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  wire scl_level;
  wire scl_toggle;
  reg [CW-1:0] half_high;
  reg [CW-1:0] half_low;
  reg [4:0] mul_high;
  reg [4:0] mul_low;
  reg [15:0] edge_count;

  // next values of the configuration and of the read answer
  reg next_fast_speed;
  reg next_duty_select;
  reg [PW-1:0] next_period_count;
  reg [6:0] next_rise_time;
  reg next_fast_plus;
  reg next_run;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets as bytes and as word indices of the decoded address
  localparam [7:0] OFF_CLK = `I2CST_OFF_CLOCK_CONFIG;
  localparam [7:0] OFF_RISE = `I2CST_OFF_RISE_TIME;
  localparam [7:0] OFF_FMP = `I2CST_OFF_FAST_PLUS;
  localparam [7:0] OFF_CTL = `I2CST_OFF_CONTROL;
  localparam [7:0] OFF_STS = `I2CST_OFF_STATUS;
  // decode looks at bits 7:2 only, so sub-word offsets alias to their word
  localparam [5:0] IDX_CLK = OFF_CLK[7:2];
  localparam [5:0] IDX_RISE = OFF_RISE[7:2];
  localparam [5:0] IDX_FMP = OFF_FMP[7:2];
  localparam [5:0] IDX_CTL = OFF_CTL[7:2];
  localparam [5:0] IDX_STS = OFF_STS[7:2];

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data are taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_held || aw_fire;
  wire have_w = w_held || w_fire;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire do_write = have_aw && have_w && !s_axi_bvalid;

  // address decode of the write
  wire wr_hit_clk = wr_addr[7:2] == IDX_CLK;
  wire wr_hit_rise = wr_addr[7:2] == IDX_RISE;
  wire wr_hit_fmp = wr_addr[7:2] == IDX_FMP;
  wire wr_hit_ctl = wr_addr[7:2] == IDX_CTL;
  wire wr_hit_sts = wr_addr[7:2] == IDX_STS;
  wire wr_known = wr_hit_clk || wr_hit_rise || wr_hit_fmp || wr_hit_ctl || wr_hit_sts;

  // hold taken address or data until its partner arrives
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end else begin
        if (aw_fire) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
    end
  end

  // write response follows both halves
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `I2CST_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `I2CST_RESP_OKAY : `I2CST_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers; byte lanes honoured, reserved bits dropped
  // lane 0 carries bits 7:0 and lane 1 bits 15:8; the upper lanes are reserved
  always @* begin
    next_fast_speed = fast_speed;
    next_duty_select = duty_select;
    next_period_count = scl_period_count;
    next_rise_time = rise_time;
    next_fast_plus = fast_plus;
    next_run = run;
    // nothing moves until both halves of a write are had
    if (do_write && wr_hit_clk) begin
      if (wr_strb[0]) begin
        next_period_count[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
        next_period_count[PW-1:8] = wr_data[PW-1:8];
        next_duty_select = wr_data[`I2CST_DUTY_BIT];
        next_fast_speed = wr_data[`I2CST_FAST_BIT];
      end
    end
    if (do_write && wr_hit_rise && wr_strb[0]) begin
      next_rise_time = wr_data[`I2CST_RISE_MSB:0];
    end
    if (do_write && wr_hit_fmp && wr_strb[0]) begin
      next_fast_plus = wr_data[`I2CST_FMP_BIT];
    end
    if (do_write && wr_hit_ctl && wr_strb[0]) begin
      next_run = wr_data[`I2CST_RUN_BIT];
    end
  end

  // configuration flip-flops, reset to their documented values
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_speed <= 1'b0;
      duty_select <= 1'b0;
      scl_period_count <= {PW{1'b0}};
      rise_time <= `I2CST_RISE_TIME_RST;
      fast_plus <= `I2CST_FAST_PLUS_RST;
      run <= 1'b0;
    end else begin
      fast_speed <= next_fast_speed;
      duty_select <= next_duty_select;
      scl_period_count <= next_period_count;
      rise_time <= next_rise_time;
      fast_plus <= next_fast_plus;
      run <= next_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one read at a time, data from a register
  assign s_axi_arready = !s_axi_rvalid;

  // read data mux; reserved and unused bits read as zero
  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = `I2CST_RESP_OKAY;
    case (s_axi_araddr[7:2])
      IDX_CLK: begin
        next_rdata[`I2CST_FAST_BIT] = fast_speed;
        next_rdata[`I2CST_DUTY_BIT] = duty_select;
        next_rdata[PW-1:0] = scl_period_count;
      end
      IDX_RISE: begin
        next_rdata[`I2CST_RISE_MSB:0] = rise_time;
      end
      IDX_FMP: begin
        next_rdata[`I2CST_FMP_BIT] = fast_plus;
      end
      IDX_CTL: begin
        next_rdata[`I2CST_RUN_BIT] = run;
      end
      // status: bit 0 the scl level, the upper half the edge count
      IDX_STS: begin
        next_rdata[0] = scl_level;
        next_rdata[31:16] = edge_count;
      end
      // unmapped words answer with an error and zero data
      default: begin
        next_rresp = `I2CST_RESP_SLVERR;
      end
    endcase
  end

  // read answer stands until taken
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `I2CST_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half period lengths from speed and duty selection
  always @* begin
    if (!fast_speed) begin
      mul_high = `I2CST_MUL_STD_HIGH;
      mul_low = `I2CST_MUL_STD_LOW;
    end else if (!duty_select) begin
      mul_high = `I2CST_MUL_FAST_HIGH;
      mul_low = `I2CST_MUL_FAST_LOW;
    end else begin
      mul_high = `I2CST_MUL_DUTY_HIGH;
      mul_low = `I2CST_MUL_DUTY_LOW;
    end
    // widen both factors so the product keeps all of its bits
    half_high = {{(CW-PW){1'b0}}, scl_period_count} * {{(CW-5){1'b0}}, mul_high};
    half_low = {{(CW-PW){1'b0}}, scl_period_count} * {{(CW-5){1'b0}}, mul_low};
  end

  ////////////////////////////////////////////////////////////////////////////
  // scl generator
  i2cst_half_timer #(
    .CW(CW)
  ) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .run(run),
    .half_high(half_high),
    .half_low(half_low),
    .scl_level(scl_level),
    .toggle(scl_toggle)
  );

  // count of scl edges, readable as status
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_count <= 16'h0000;
    end else if (!run) begin
      edge_count <= 16'h0000;
    end else if (scl_toggle) begin
      edge_count <= edge_count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open drain: enable low pulls the line, released high
  assign scl_out = 1'b0;
  assign scl_oe_n = scl_level;

  // configuration copies for the pad and the rise-time logic outside
  assign fast_plus_enable = fast_plus;
  assign rise_time_limit = rise_time;
endmodule

// [tb/i2cst_scl_timing_props.sv]
`timescale 1ns/1ps
module i2cst_scl_timing_props (
  input wire clk,
  input wire arst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire scl_out,
  input wire scl_oe_n,
  input wire [6:0] rise_time_limit
);
  // all checks on the one clock, quiet in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_scl_data_low: assert property (scl_out == 1'b0)
    else $error("scl data not low");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  a_rise_by_write: assert property ($changed(rise_time_limit) |-> $rose(s_axi_bvalid))
    else $error("rise limit moved alone");
  a_scl_after_reset: assert property ($rose(arst_n) |-> scl_oe_n)
    else $error("scl not released after reset");
  a_rise_after_reset: assert property ($rose(arst_n) |-> rise_time_limit == 7'h02)
    else $error("rise limit reset value wrong");
endmodule

// [tb/i2cst_slave_model.sv]
`timescale 1ns/1ps
module i2cst_slave_model (
  input wire clk,
  input wire scl_out,
  input wire scl_oe_n,
  output wire scl,
  output reg [31:0] hi_len,
  output reg [31:0] lo_len,
  output reg [31:0] edges
);
  reg prev = 1'b1;
  reg [31:0] run_len = 32'h0000_0000;
  // pull-up: a released line reads high
  assign scl = scl_oe_n ? 1'b1 : scl_out;
  initial begin
    hi_len = 32'h0000_0000;
    lo_len = 32'h0000_0000;
    edges = 32'h0000_0000;
  end
  // measure each level in clock cycles as a listening slave would
  always @(posedge clk) begin
    if (scl !== prev) begin
      if (prev) hi_len <= run_len;
      else lo_len <= run_len;
      edges <= edges + 1;
      run_len <= 32'h0000_0001;
    end else run_len <= run_len + 1;
    prev <= scl;
  end
endmodule

// [tb/i2cst_scl_timing_tb.sv]
`timescale 1ns/1ps
module i2cst_scl_timing_tb;
  logic clk = 0, arst_n = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic [7:0] aw_a = 0, ar_a = 0;
  logic [31:0] w_d = 0, rd, cfg;
  logic [3:0] w_s = 0;
  logic [1:0] rs;
  logic [11:0] cnt;
  wire aw_rdy, w_rdy, b_v, ar_rdy, r_v, scl_out, scl_oe_n, fpe, scl;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_d, hi_len, lo_len, edges;
  wire [6:0] rtl;
  int err_total = 0, checked = 0, e0;
  always #2.5 clk = ~clk;
  i2cst_scl_timing i_dut (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .fast_plus_enable(fpe), .rise_time_limit(rtl));
  i2cst_slave_model i_slave (.clk(clk), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .scl(scl),
    .hi_len(hi_len), .lo_len(lo_len), .edges(edges));
  ////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task summarize;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // axi write: hold each channel until taken; bready may rise a few cycles late
  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
    int k;
    int h;
    k = 0;
    h = $urandom % 3;
    aw_a <= a; w_d <= d; w_s <= s; aw_v <= 1; w_v <= 1; b_r <= (h == 0);
    do begin
      @(posedge clk);
      if (aw_v && aw_rdy) aw_v <= 0;
      if (w_v && w_rdy) w_v <= 0;
      k++;
      if (k >= h && !b_r) b_r <= 1;
    end while (!(b_v && b_r));
    r = b_resp; b_r <= 0;
    @(posedge clk);
  endtask
  // axi read: rready may rise a few cycles late, data taken with the handshake
  task automatic rdr(input [7:0] a, output [31:0] d, output [1:0] r);
    int k;
    int h;
    k = 0;
    h = $urandom % 3;
    ar_a <= a; ar_v <= 1; r_r <= (h == 0);
    do begin
      @(posedge clk);
      if (ar_v && ar_rdy) ar_v <= 0;
      k++;
      if (k >= h && !r_r) r_r <= 1;
    end while (!(r_v && r_r));
    d = r_d; r = r_resp; r_r <= 0;
    @(posedge clk);
  endtask
  // expected half-period length in clock cycles
  function automatic [31:0] half(input f, input dy, input hi, input [11:0] c);
    if (!f) return {20'h0, c};
    if (!dy) return hi ? {20'h0, c} : {19'h0, c, 1'b0};
    return hi ? 32'h0000_0009 * c : 32'h0000_0010 * c;
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h4f77));
    repeat (3) @(posedge clk);
    arst_n <= 1;
    rdr(8'h1c, rd, rs); chk("clock_config", 32'h0000_0000, rd);
    rdr(8'h20, rd, rs); chk("scl_rise_time", 32'h0000_0002, rd);
    chk("rise_time_limit", 32'h0000_0002, {25'h0, rtl});
    rdr(8'h90, rd, rs); chk("fast_plus_config", 32'h0000_0000, rd);
    cnt = 12'($urandom);
    wr(8'h20, {25'h0, cnt[6:0]}, 4'b0011, rs);
    rdr(8'h20, rd, rs); chk("rise half word", {25'h0, cnt[6:0]}, rd);
    wr(8'h20, 32'h0000_0000, 4'b1100, rs);
    chk("rise upper lanes", {25'h0, cnt[6:0]}, {25'h0, rtl});
    for (int v = 1; v >= 0; v--) begin
      wr(8'h90, v, 4'b0011, rs);
      chk("fast_plus_enable", v, {31'h0, fpe});
    end
    wr(8'h40, 32'h0000_0001, 4'hf, rs); chk("unmapped bresp", 32'h0000_0002, {30'h0, rs});
    rdr(8'h40, rd, rs); chk("unmapped rresp", 32'h0000_0002, {30'h0, rs});
    // modes: standard, fast, fast with duty, standard with the duty bit ignored
    for (int m = 0; m < 4; m++) begin
      cnt = 12'(2 + $urandom % 4);
      cfg = {16'h0, m == 1 || m == 2, m >= 2, 2'b00, cnt};
      wr(8'h94, 32'h0000_0000, 4'hf, rs);
      chk("scl idle", 32'h0000_0001, {31'h0, scl});
      rdr(8'h98, rd, rs); chk("status idle", 32'h0000_0001, rd);
      wr(8'h1c, cfg, 4'hf, rs);
      rdr(8'h1c, rd, rs); chk("clock_config", cfg, rd);
      wr(8'h94, 32'h0000_0001, 4'hf, rs);
      e0 = edges;
      for (int i = 0; i < 600 && edges < e0 + 5; i++) @(posedge clk);
      chk("scl edge count", e0 + 5, edges);
      chk("scl high", half(cfg[15], cfg[14], 1'b1, cnt), hi_len);
      chk("scl low", half(cfg[15], cfg[14], 1'b0, cnt), lo_len);
    end
    summarize;
  end
  // watchdog cuts a hang short
  initial begin
    #100us;
    err_total++;
    summarize;
  end
endmodule
bind i2cst_scl_timing i2cst_scl_timing_props i_props (.clk(clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
  .rise_time_limit(rise_time_limit));
